// [rtl/trid_top.v]
// Translation result register and identification window on AHB-Lite.
// Assumes the translation unit on hclk drives busy, done and outcome.
//
// Overview of operation
// RL1: Result bit 0 selects layout: zero success, one fault syndrome.
// RL2: Success holds attribute byte, address, size, final nonsecure and shareability.
// RL3: Address outside 51:12 is zero; earliest major_b zeroes bits 51:48.
// RL4: Shareability codes 00 non, 10 outer, 11 inner; 01 never returned.
// RL5: Device memory attribute always reports outer shareable.
// RL6: Size flag zero means 4KB; one means lowest set address bit.
// RL7: Address aligned to size; above 4KB bit N marks size 2^(N+1).
// RL8: May report cached attributes or cached block size instead.
// RL9: Attributes come from tables only, no stream overrides applied.
// RL10: Stage-2-only returns stage 2 attributes, allocate hints 1, transient 0.
// RL11: Stage-1-only returns stage 1; two-stage returns combined attributes.
// RL12: Fault holds impl data, fault page address, code, space bit, class.
// RL13: Secure-stream IPA fault space bit is stage 1 nonsecure or stream config.
// RL14: Space bit zero without IPA, nonsecure stream, old major_b, no secure stage 2.
// RL15: Cause class 00 stage1/other, 01 descriptor, 10 walk, 11 input.
// RL16: Result unknown while busy or after request change; software must wait.
// RL17: Read-only ID window 0xFD0 to 0xFFC, eight bits each.
// RL18: Component IDs give preamble bytes; second has class above preamble.
// RL19: Part number bits 7:0 in first, 11:8 in second low nibble.
// RL20: Third peripheral ID bit 3 set; designer code spread over fields.
// RL21: Undefined ID fields and peripheral IDs 5 to 7 read zero.
// RL22: Reads have no side effect; writes to result and IDs ignored.
//
// Register access over AHB-Lite was decided locally.
`timescale 1ns/10ps
`include "trid_regs.vh"

module trid_top
#(
   parameter [1:0] ARCH_REV = 2'd2,
   parameter SEC_S2_SUPPORTED = 1'b1,
   parameter [11:0] PART_NUM = `TRID_DEF_PART,
   parameter [6:0] DESIGNER = `TRID_DEF_DESIGNER,
   parameter [3:0] DESIGNER_CONT = `TRID_DEF_CONT,
   parameter [3:0] MAJOR_REV = 4'h0,
   parameter [3:0] MINOR_REV = 4'h0,
   parameter [3:0] CUST_MOD = 4'h0,
   parameter [3:0] COMP_CLASS = `TRID_DEF_CLASS,
   parameter [7:0] PREAMBLE0 = `TRID_DEF_PREAMBLE0,
   parameter [3:0] PREAMBLE1 = `TRID_DEF_PREAMBLE1,
   parameter [7:0] PREAMBLE2 = `TRID_DEF_PREAMBLE2,
   parameter [7:0] PREAMBLE3 = `TRID_DEF_PREAMBLE3
)
(
   input wire hclk,
   input wire hresetn,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output reg hreadyout,
   output reg hresp,
   output reg [31:0] hrdata,
   input wire op_busy,
   input wire op_done,
   input wire req_modified,
   input wire [1:0] req_type,
   input wire secure_stream_select,
   input wire fault,
   input wire [51:12] out_addr,
   input wire [5:0] table_size_log2,
   input wire [5:0] cached_size_log2,
   input wire [7:0] s1_memory_byte_a,
   input wire [3:0] s2_mem_type,
   input wire [1:0] s1_shareability,
   input wire [1:0] s2_shareability,
   input wire final_nonsecure_bit,
   input wire [3:0] impl_specific_data,
   input wire [51:12] fault_page_address,
   input wire ipa_reported,
   input wire [7:0] failure_code,
   input wire s1_bypassed,
   input wire stream_nonsec_cfg,
   input wire s1_nonsec_out,
   input wire [1:0] fault_class
);

   ////////////////////////////////////////////////////////////////////////
   // Attribute helpers

   // Stage 2 two-bit attribute field to byte-format nibble, allocate hints forced
   function [3:0] s2_nib;
      input [1:0] c;
      begin
         case (c)
            2'b01: s2_nib = 4'b0100;
            2'b10: s2_nib = 4'b1011;
            default: s2_nib = 4'b1111;
         endcase
      end
   endfunction

   // Cacheability rank of a byte-format nibble: 0 NC, 1 WT, 2 WB
   function [1:0] rank;
      input [3:0] n;
      begin
         if (n == 4'b0100)
            rank = 2'd0;
         else if (!n[2])
            rank = 2'd1;
         else
            rank = 2'd2;
      end
   endfunction

   // Weaker of two nibbles wins
   function [3:0] comb_nib;
      input [3:0] a;
      input [3:0] b;
      begin
         if (rank(a) <= rank(b))
            comb_nib = a;
         else
            comb_nib = b;
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Declarations
   wire [63:0] result_r;
   wire s1_dev;
   wire s2_dev;
   wire [1:0] dt1;
   wire [1:0] dt2;
   wire [7:0] s2_byte;
   wire [7:0] comb_byte;
   reg [7:0] byte_sel;
   reg [1:0] share_raw;
   reg [1:0] share_fin;
   wire [5:0] sz;
   wire [39:0] al_addr;
   wire [39:0] rep_addr;
   wire size_flag;
   wire ipa_space;
   wire [63:0] ok_word;
   wire [63:0] fault_word;
   wire [63:0] result_nxt;
   reg ctrl_cached_size_r;
   reg taint_r;
   reg stale_r;
   reg valid_r;
   reg wr_pend_r;
   reg [11:0] wr_addr_r;
   reg [31:0] rd_word;
   wire [11:0] a_off;
   wire acc;

   ////////////////////////////////////////////////////////////////////////
   // Attribute selection by request type
   assign s1_dev = (s1_memory_byte_a[7:4] == 4'h0);
   assign s2_dev = (s2_mem_type[3:2] == 2'b00);
   assign dt1 = s1_dev ? s1_memory_byte_a[3:2] : 2'b11;
   assign dt2 = s2_dev ? s2_mem_type[1:0] : 2'b11;
   // RL10: stage 2 hints
   assign s2_byte = s2_dev ? {4'h0, s2_mem_type[1:0], 2'b00}
                           : {s2_nib(s2_mem_type[3:2]), s2_nib(s2_mem_type[1:0])};
   // RL11: two-stage combine
   assign comb_byte = (s1_dev || s2_dev) ? {4'h0, ((dt1 < dt2) ? dt1 : dt2), 2'b00}
                    : {comb_nib(s1_memory_byte_a[7:4], s2_byte[7:4]),
                       comb_nib(s1_memory_byte_a[3:0], s2_byte[3:0])};

   // RL9: table attributes only
   always @*
   begin
      case (req_type)
         `TRID_TYPE_S2:
         begin
            byte_sel = s2_byte;
            share_raw = s2_shareability;
         end
         `TRID_TYPE_S12:
         begin
            byte_sel = comb_byte;
            if (s1_shareability == `TRID_SHARE_OUTER || s2_shareability == `TRID_SHARE_OUTER)
               share_raw = `TRID_SHARE_OUTER;
            else if (s1_shareability == `TRID_SHARE_INNER || s2_shareability == `TRID_SHARE_INNER)
               share_raw = `TRID_SHARE_INNER;
            else
               share_raw = `TRID_SHARE_NON;
         end
         default:
         begin
            byte_sel = s1_memory_byte_a;
            share_raw = s1_shareability;
         end
      endcase
   end

   // Final shareability code
   always @*
   begin
      // RL5: device is outer
      if (byte_sel[7:4] == 4'h0)
         share_fin = `TRID_SHARE_OUTER;
      // RL4: reserved code mapped away
      else if (share_raw == 2'b01)
         share_fin = `TRID_SHARE_OUTER;
      else
         share_fin = share_raw;
   end

   ////////////////////////////////////////////////////////////////////////
   // Size encoding in the address field
   // RL8: cached size option
   assign sz = ctrl_cached_size_r ? cached_size_log2 : table_size_log2;
   // RL6: size flag
   assign size_flag = (sz > `TRID_PAGE_SHIFT);

   // RL7: align then mark size bit
   genvar gi;
   generate
      for (gi = 12; gi < 52; gi = gi + 1)
      begin : g_al
         assign al_addr[gi-12] = ({26'h0, sz} <= gi) ? out_addr[gi]
                               : (({26'h0, sz} == gi + 1) && size_flag);
      end
   endgenerate

   // RL3: earliest major_b clears top nibble
   assign rep_addr = (ARCH_REV == 2'd0) ? {4'h0, al_addr[35:0]} : al_addr;

   // RL13: space bit source
   // RL14: zero cases
   assign ipa_space = ipa_reported && secure_stream_select && (ARCH_REV >= 2'd2)
                  && SEC_S2_SUPPORTED && (s1_bypassed ? stream_nonsec_cfg : s1_nonsec_out);

   // RL2: success layout
   assign ok_word = {byte_sel, 4'h0, rep_addr, size_flag, final_nonsecure_bit,
                     share_fin, 7'h00, 1'b0};

   // RL12: fault layout
   // RL15: class passed in bits 2:1
   assign fault_word = {impl_specific_data, 8'h00,
                        ((ARCH_REV == 2'd0) ? {4'h0, fault_page_address[47:12]}
                                            : fault_page_address),
                        failure_code, ipa_space, fault_class, 1'b1};

   // RL1: fault bit picks layout
   assign result_nxt = fault ? fault_word : ok_word;

   trid_result_store trid_result_store_inst
   (
      .hclk(hclk),
      .hresetn(hresetn),
      .capture(op_done),
      .result_nxt(result_nxt),
      .result_r(result_r)
   );

   ////////////////////////////////////////////////////////////////////////
   // Operation bookkeeping
   // RL16: request change taints result
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         taint_r <= 1'b0;
         stale_r <= 1'b0;
         valid_r <= 1'b0;
      end
      else
      begin
         if (op_done)
         begin
            stale_r <= taint_r | (op_busy & req_modified);
            valid_r <= 1'b1;
            taint_r <= 1'b0;
         end
         else if (op_busy && req_modified)
         begin
            taint_r <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Bus slave
   assign a_off = {haddr[11:2], 2'b00};
   assign acc = hsel && htrans[1] && hready;

   // Read multiplexer evaluated in the address phase
   always @*
   begin
      rd_word = 32'h0;
      case (a_off)
         // RL16: busy reads give zero
         `TRID_OFF_RESULT_LO: rd_word = op_busy ? 32'h0 : result_r[31:0];
         `TRID_OFF_RESULT_HI: rd_word = op_busy ? 32'h0 : result_r[63:32];
         `TRID_OFF_STATUS: rd_word = {29'h0, valid_r, stale_r, op_busy};
         `TRID_OFF_CTRL: rd_word = {31'h0, ctrl_cached_size_r};
         // RL17: identification window
         // RL19: part number split
         `TRID_OFF_PID0: rd_word = {24'h0, PART_NUM[7:0]};
         `TRID_OFF_PID1: rd_word = {24'h0, DESIGNER[3:0], PART_NUM[11:8]};
         // RL20: designer code fields
         `TRID_OFF_PID2: rd_word = {24'h0, MAJOR_REV, 1'b1, DESIGNER[6:4]};
         `TRID_OFF_PID3: rd_word = {24'h0, MINOR_REV, CUST_MOD};
         `TRID_OFF_PID4: rd_word = {28'h0, DESIGNER_CONT};
         // RL21: unused IDs zero
         `TRID_OFF_PID5: rd_word = 32'h0;
         `TRID_OFF_PID6: rd_word = 32'h0;
         `TRID_OFF_PID7: rd_word = 32'h0;
         // RL18: preamble and class
         `TRID_OFF_CID0: rd_word = {24'h0, PREAMBLE0};
         `TRID_OFF_CID1: rd_word = {24'h0, COMP_CLASS, PREAMBLE1};
         `TRID_OFF_CID2: rd_word = {24'h0, PREAMBLE2};
         `TRID_OFF_CID3: rd_word = {24'h0, PREAMBLE3};
         default: rd_word = 32'h0;
      endcase
   end

   // Zero-wait answer; read data registered at the address phase
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         hreadyout <= 1'b1;
         hresp <= `TRID_HRESP_OKAY;
         hrdata <= 32'h0;
         wr_pend_r <= 1'b0;
         wr_addr_r <= 12'h000;
      end
      else
      begin
         hreadyout <= 1'b1;
         hresp <= `TRID_HRESP_OKAY;
         // RL22: reads have no side effect
         if (acc && !hwrite)
         begin
            hrdata <= rd_word;
         end
         if (hready)
         begin
            wr_pend_r <= acc && hwrite;
            wr_addr_r <= a_off;
         end
      end
   end

   // Only the control word is writable
   // RL22: other writes ignored
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ctrl_cached_size_r <= `TRID_CTRL_RST;
      end
      else if (wr_pend_r && wr_addr_r == `TRID_OFF_CTRL)
      begin
         ctrl_cached_size_r <= hwdata[0];
      end
   end

endmodule

// [rtl/trid_regs.vh]
// Register map, field positions, reset values and ID defaults of the
// translation result and identification register bank.
// Assumes a 32-bit AHB-Lite slave decoding a 4KB page, byte offsets.
`ifndef TRID_REGS_VH
`define TRID_REGS_VH

////////////////////////////////////////////////////////////////////////////
// Word offsets within the page
`define TRID_OFF_RESULT_LO 12'h000
`define TRID_OFF_RESULT_HI 12'h004
`define TRID_OFF_STATUS 12'h008
`define TRID_OFF_CTRL 12'h00c
`define TRID_OFF_PID4 12'hfd0
`define TRID_OFF_PID5 12'hfd4
`define TRID_OFF_PID6 12'hfd8
`define TRID_OFF_PID7 12'hfdc
`define TRID_OFF_PID0 12'hfe0
`define TRID_OFF_PID1 12'hfe4
`define TRID_OFF_PID2 12'hfe8
`define TRID_OFF_PID3 12'hfec
`define TRID_OFF_CID0 12'hff0
`define TRID_OFF_CID1 12'hff4
`define TRID_OFF_CID2 12'hff8
`define TRID_OFF_CID3 12'hffc

////////////////////////////////////////////////////////////////////////////
// Result register fields
`define TRID_FAULT_BIT 0
`define TRID_SIZE_BIT 11
`define TRID_FINAL_NONSEC_BIT 10
`define TRID_IPA_SPACE_BIT 3
`define TRID_PAGE_SHIFT 6'd12
`define TRID_ADDR_HI 51
`define TRID_ADDR_LO 12

// Shareability codes
`define TRID_SHARE_NON 2'b00
`define TRID_SHARE_OUTER 2'b10
`define TRID_SHARE_INNER 2'b11

// Request types
`define TRID_TYPE_S1 2'b01
`define TRID_TYPE_S2 2'b10
`define TRID_TYPE_S12 2'b11

// Reset values
`define TRID_RESULT_RST 64'h0000000000000000
`define TRID_CTRL_RST 1'b0
`define TRID_HRESP_OKAY 1'b0

// Identification defaults (arbitrary values, not any real maker's)
`define TRID_DEF_PREAMBLE0 8'h11
`define TRID_DEF_PREAMBLE1 4'h2
`define TRID_DEF_PREAMBLE2 8'h33
`define TRID_DEF_PREAMBLE3 8'h44
`define TRID_DEF_CLASS 4'h9
`define TRID_DEF_PART 12'h123
`define TRID_DEF_DESIGNER 7'h2a
`define TRID_DEF_CONT 4'h1

`endif

// [rtl/trid_result_store.v]
// Holding register for the 64-bit translation result word.
// Assumes the capture strobe and next value come from logic on hclk.
`timescale 1ns/10ps
`include "trid_regs.vh"

module trid_result_store
(
   input wire hclk,
   input wire hresetn,
   input wire capture,
   input wire [63:0] result_nxt,
   output reg [63:0] result_r
);

   ////////////////////////////////////////////////////////////////////////
   // Result word loads only on a completed operation
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         result_r <= `TRID_RESULT_RST;
      end
      else if (capture)
      begin
         result_r <= result_nxt;
      end
   end

endmodule

// [testbench/trid_top_chk.sv]
// Bus-side checker for the result and ID register bank.
// Assumes one AHB-Lite master and the default ID parameters.
`timescale 1ns/10ps
`include "trid_regs.vh"

module trid_top_chk
(
   input wire hclk,
   input wire hresetn,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire hready,
   input wire hreadyout,
   input wire hresp,
   input wire [31:0] hrdata,
   input wire op_busy
);
   localparam [11:0] PN = `TRID_DEF_PART;
   localparam [6:0] DS = `TRID_DEF_DESIGNER;
   wire rd_take;
   wire [11:0] off;

   // Read accepted and its page offset
   assign rd_take = hsel & htrans[1] & hready & ~hwrite;
   assign off = haddr[11:0];

   default clocking dcb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   ////////////////////////////////////////////////////////////////////////////
   AST_OKAY_READY: assert property (hreadyout && !hresp)
      else $error("answer not zero-wait okay");
   AST_CID0: assert property (rd_take && off == 12'hff0 |=> hrdata == {24'h0, `TRID_DEF_PREAMBLE0})
      else $error("component id 0 wrong");
   AST_CID1: assert property (rd_take && off == 12'hff4 |=>
      hrdata == {24'h0, `TRID_DEF_CLASS, `TRID_DEF_PREAMBLE1})
      else $error("component id 1 wrong");
   AST_PART: assert property (rd_take && off == 12'hfe0 |=> hrdata == {24'h0, PN[7:0]})
      else $error("part number low wrong");
   AST_PID2: assert property (rd_take && off == 12'hfe8 |=> hrdata[3:0] == {1'b1, DS[6:4]})
      else $error("peripheral id 2 wrong");
   AST_PID_ZERO: assert property (rd_take && off inside {12'hfd4, 12'hfd8, 12'hfdc} |=> hrdata == 32'h0)
      else $error("reserved id not zero");
   AST_ID_BYTE: assert property (rd_take && off >= 12'hfd0 |=> hrdata[31:8] == 24'h0)
      else $error("id upper bits not zero");
   AST_BUSY_ZERO: assert property (rd_take && op_busy && off[11:3] == 9'h0 |=> hrdata == 32'h0)
      else $error("result read while busy not zero");
   AST_SUCC_FMT: assert property (rd_take && !op_busy && off == 12'h000 ##1 !hrdata[0] |->
      hrdata[7:1] == 7'h0 && hrdata[9:8] != 2'b01)
      else $error("success layout wrong");
   AST_HOLD: assert property (!rd_take |=> $stable(hrdata))
      else $error("read data moved without read");
endmodule

bind trid_top trid_top_chk trid_top_chk_inst
(
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
   .hrdata(hrdata), .op_busy(op_busy)
);

// [testbench/trid_top_test.sv]
// Self-checking bench for the result and ID register bank.
// Assumes a zero-wait AHB-Lite slave and default parameters.
`timescale 1ns/10ps
`include "trid_regs.vh"

module trid_top_test;
   localparam [11:0] PN = `TRID_DEF_PART;
   localparam [6:0] DS = `TRID_DEF_DESIGNER;
   logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, op_busy = 1'b0;
   logic op_done = 1'b0, req_modified = 1'b0, fault = 1'b0, final_nonsecure_bit = 1'b0;
   logic secure_stream_select = 1'b0, ipa_reported = 1'b0, s1_bypassed = 1'b0;
   logic stream_nonsec_cfg = 1'b0, s1_nonsec_out = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
   logic [1:0] htrans = 2'b00, req_type = 2'b01, fault_class = 2'b00;
   logic [1:0] s1_shareability = 2'b11, s2_shareability = 2'b11;
   logic [2:0] hsize = 3'h2;
   logic [51:12] out_addr = 40'h0, fault_page_address = 40'h0;
   logic [5:0] table_size_log2 = 6'd12, cached_size_log2 = 6'd12;
   logic [7:0] s1_memory_byte_a = 8'hff, failure_code = 8'h0;
   logic [3:0] s2_mem_type = 4'hf, impl_specific_data = 4'h0;
   logic [63:0] res;
   wire hready, hresp;
   wire [31:0] hrdata;
   integer n_mismatch = 0, num_checks = 0;

   // Design under test
   trid_top trid_top_inst
   (
      .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
      .hreadyout(hready), .hresp, .hrdata, .op_busy, .op_done, .req_modified, .req_type,
      .secure_stream_select, .fault, .out_addr, .table_size_log2, .cached_size_log2,
      .s1_memory_byte_a, .s2_mem_type, .s1_shareability, .s2_shareability,
      .final_nonsecure_bit, .impl_specific_data, .fault_page_address, .ipa_reported,
      .failure_code, .s1_bypassed, .stream_nonsec_cfg, .s1_nonsec_out, .fault_class
   );

   // 100 MHz clock
   always #5 hclk = ~hclk;

   ////////////////////////////////////////////////////////////////////////////
   // Counts and verdict
   task report_and_stop;
      begin
         $display("checks %0d mismatches %0d", num_checks, n_mismatch);
         if (n_mismatch == 0 && num_checks > 0)
            $display("TEST PASSED");
         else
            $display("TEST FAILED");
         $finish;
      end
   endtask

   // Compare and count
   task chk(input logic [63:0] got, input logic [63:0] exp);
      begin
         num_checks = num_checks + 1;
         if (got !== exp)
         begin
            n_mismatch = n_mismatch + 1;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
         end
      end
   endtask

   // Bounded wait for hready at an edge
   task wait_rdy;
      integer i;
      begin
         i = 0;
         @(posedge hclk);
         while (hready !== 1'b1 && i < 20)
         begin
            i = i + 1;
            @(posedge hclk);
         end
         if (hready !== 1'b1)
         begin
            n_mismatch = n_mismatch + 1;
            report_and_stop;
         end
      end
   endtask

   // One single-word transfer, entered just after an edge
   task bus(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      begin
         hsel <= 1'b1;
         haddr <= {20'h0, a};
         htrans <= 2'b10;
         hwrite <= wr;
         wait_rdy;
         htrans <= 2'b00;
         hwdata <= wd;
         wait_rdy;
         rd = hrdata;
      end
   endtask

   // Run one operation, then read both result halves
   task op;
      begin
         op_busy <= 1'b1;
         @(posedge hclk);
         op_done <= 1'b1;
         @(posedge hclk);
         op_done <= 1'b0;
         op_busy <= 1'b0;
         @(posedge hclk);
         bus(1'b0, 12'h000, 32'h0);
         res[31:0] = rd;
         bus(1'b0, 12'h004, 32'h0);
         res[63:32] = rd;
      end
   endtask

   // Expected success word, final nonsecure set
   function logic [63:0] sw(input logic [7:0] at, input logic [39:0] ad, input logic sz,
      input logic [1:0] share);
      return {at, 4'h0, ad, sz, 1'b1, share, 8'h0};
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // ID window after a write attempt, then an unmapped read
   task t_ids;
      logic [7:0] e [0:11];
      integer k;
      begin
         e = '{{4'h0, `TRID_DEF_CONT}, 8'h0, 8'h0, 8'h0, PN[7:0], {DS[3:0], PN[11:8]},
            {4'h0, 1'b1, DS[6:4]}, 8'h0, `TRID_DEF_PREAMBLE0,
            {`TRID_DEF_CLASS, `TRID_DEF_PREAMBLE1}, `TRID_DEF_PREAMBLE2, `TRID_DEF_PREAMBLE3};
         bus(1'b1, 12'hff0, 32'hffffffff);
         for (k = 0; k < 12; k = k + 1)
         begin
            bus(1'b0, 12'(12'hfd0 + k * 4), 32'h0);
            chk({32'h0, rd}, {56'h0, e[k]});
         end
         bus(1'b0, 12'h100, 32'h0);
         chk({32'h0, rd}, 64'h0);
      end
   endtask

   // Success layouts: stage kinds, sizes, cached size, device type
   task t_res;
      begin
         final_nonsecure_bit <= 1'b1;
         out_addr <= 40'hf123456789;
         s2_mem_type <= 4'b1010;
         s2_shareability <= 2'b10;
         op;
         chk(res, sw(8'hff, 40'hf123456789, 1'b0, 2'b11));
         req_type <= 2'b10;
         op;
         chk(res, sw(8'hbb, 40'hf123456789, 1'b0, 2'b10));
         req_type <= 2'b11;
         op;
         chk(res, sw(8'hbb, 40'hf123456789, 1'b0, 2'b10));
         req_type <= 2'b01;
         table_size_log2 <= 6'd16;
         op;
         chk(res, sw(8'hff, 40'hf123456788, 1'b1, 2'b11));
         cached_size_log2 <= 6'd21;
         bus(1'b1, 12'h00c, 32'h1);
         op;
         chk(res, sw(8'hff, 40'hf123456700, 1'b1, 2'b11));
         bus(1'b1, 12'h00c, 32'h0);
         s1_memory_byte_a <= 8'h04;
         op;
         chk(res, sw(8'h04, 40'hf123456788, 1'b1, 2'b10));
      end
   endtask

   // Fault syndrome over every cause class
   task t_fault;
      integer k;
      logic ipa_space;
      begin
         fault <= 1'b1;
         impl_specific_data <= 4'ha;
         fault_page_address <= 40'h0abcdef012;
         failure_code <= 8'h5a;
         ipa_reported <= 1'b1;
         for (k = 0; k < 4; k = k + 1)
         begin
            fault_class <= k[1:0];
            secure_stream_select <= (k != 1);
            s1_bypassed <= (k == 2);
            stream_nonsec_cfg <= (k == 2);
            s1_nonsec_out <= (k != 2);
            ipa_space = (k != 1);
            op;
            chk(res, {4'ha, 8'h0, 40'h0abcdef012, 8'h5a, ipa_space, k[1:0], 1'b1});
         end
         fault <= 1'b0;
      end
   endtask

   // Request change during an operation marks the result stale
   task t_stale;
      begin
         op_busy <= 1'b1;
         req_modified <= 1'b1;
         @(posedge hclk);
         req_modified <= 1'b0;
         op_done <= 1'b1;
         @(posedge hclk);
         op_done <= 1'b0;
         op_busy <= 1'b0;
         @(posedge hclk);
         bus(1'b0, 12'h008, 32'h0);
         chk({32'h0, rd}, 64'h6);
         op;
         bus(1'b0, 12'h008, 32'h0);
         chk({32'h0, rd}, 64'h4);
      end
   endtask

   // Result read while an operation runs
   task t_busy;
      begin
         op_busy <= 1'b1;
         bus(1'b0, 12'h004, 32'h0);
         chk({32'h0, rd}, 64'h0);
         op_busy <= 1'b0;
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Reset, scenarios, verdict
   initial
   begin
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_ids;
      t_res;
      t_fault;
      t_stale;
      t_busy;
      report_and_stop;
   end
endmodule
